// ==== design/sar_adc_parallel_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// - chip select and read combine through one and; either may lead
// - result reaches the bus only once both selects are low
// - bus outputs enabled only while both selects are low
// - both tied low keeps bus driven; new result appears before busy falls
// - start falling edge switches to hold and starts conversion
// - a start low pulse of 15 ns is a valid trigger
// - busy rises after the start edge and stays high through conversion
// - conversion lasts 14 master clocks (12-bit) or 12 (10-bit)
// - busy falls only after the result is in the output register
// - track resumes just before busy falls; acquisition starts then
// - start still low when busy falls puts the part to sleep
// - rising start edge wakes from sleep; wake-up takes about 1 us
// - master clock gated off while not converting
// - result bus is 10 or 12 bits wide by variant
// - result is unsigned straight binary
module sar_adc_parallel_readout #(
    parameter int RESULT_BITS = sar_adc_pkg::RESULT_BITS_12,
    parameter int CONV_CYCLES = sar_adc_pkg::CONV_CYCLES_12BIT
) (
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     conversionStart_n,
    input  wire logic                     masterClock,
    input  wire logic                     chipSelect_n,
    input  wire logic                     read_n,
    input  wire logic [RESULT_BITS-1:0]   sampleCode,
    output logic      [RESULT_BITS-1:0]   resultBus,
    output logic      [RESULT_BITS-1:0]   resultBusOe_n,
    output logic                          busy,
    output logic                          trackHold,
    output logic                          sleeping,
    output logic                          masterClockGate
);
    import sar_adc_pkg::*;

    // control pins are asynchronous: two flops before any logic; sampleCode is taken directly
    logic [1:0] startSync_ff, mclkSync_ff, csSync_ff, rdSync_ff;
    logic       startPrev_ff, mclkPrev_ff;
    always_ff @(posedge clock) begin
        if (reset) begin
            startSync_ff <= 2'h3;
            mclkSync_ff  <= 2'h0;
            csSync_ff    <= 2'h3;
            rdSync_ff    <= 2'h3;
            startPrev_ff <= 1'h1;
            mclkPrev_ff  <= 1'h0;
        end else begin
            startSync_ff <= {startSync_ff[0], conversionStart_n};
            mclkSync_ff  <= {mclkSync_ff[0], masterClock};
            csSync_ff    <= {csSync_ff[0], chipSelect_n};
            rdSync_ff    <= {rdSync_ff[0], read_n};
            startPrev_ff <= startSync_ff[1];
            mclkPrev_ff  <= mclkSync_ff[1];
        end
    end

    logic startLow, startFall, startRise, mclkRise;
    // 15 ns is three cycles at 200 MHz, so two-flop sampling still sees it
    assign startLow  = ~startSync_ff[1];
    assign startFall = startPrev_ff & ~startSync_ff[1];
    assign startRise = ~startPrev_ff & startSync_ff[1];
    assign mclkRise  = mclkSync_ff[1] & ~mclkPrev_ff;

    conv_state_type                 state_ff, nxt_state;
    logic [CONV_WIDTH-1:0]          convCount_ff, nxt_convCount;
    logic [WAKE_WIDTH-1:0]          wakeCount_ff, nxt_wakeCount;
    logic [RESULT_BITS-1:0]         holdCode_ff, nxt_holdCode;
    logic [RESULT_BITS-1:0]         outReg_ff, nxt_outReg;

    localparam logic [CONV_WIDTH-1:0] CONV_LAST =
        CONV_WIDTH'(CONV_CYCLES - 1);
    localparam logic [WAKE_WIDTH-1:0] WAKE_LAST =
        WAKE_WIDTH'(WAKEUP_CYCLES - 1);

    logic convDone;
    assign convDone = (state_ff == ST_CONV) && mclkRise
                      && (convCount_ff == CONV_LAST);

    always_comb begin
        nxt_state     = state_ff;
        nxt_convCount = convCount_ff;
        nxt_wakeCount = wakeCount_ff;
        nxt_holdCode  = holdCode_ff;
        nxt_outReg    = outReg_ff;
        case (state_ff)
            ST_TRACK: begin
                if (startFall) begin
                    nxt_state     = ST_CONV;
                    nxt_holdCode  = sampleCode;
                    nxt_convCount = '0;
                end
            end
            ST_CONV: begin
                if (mclkRise) begin
                    nxt_convCount = convCount_ff + 1'b1;
                end
                if (convDone) begin
                    nxt_outReg = holdCode_ff;
                    // start still low at end of conversion: auto sleep
                    nxt_state  = startLow ? ST_SLEEP : ST_TRACK;
                end
            end
            ST_SLEEP: begin
                if (startRise) begin
                    nxt_state     = ST_WAKE;
                    nxt_wakeCount = '0;
                end
            end
            ST_WAKE: begin
                // triggers during wake-up are ignored; host must wait
                nxt_wakeCount = wakeCount_ff + 1'b1;
                if (wakeCount_ff == WAKE_LAST) begin
                    nxt_state = ST_TRACK;
                end
            end
            default: nxt_state = ST_TRACK;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff     <= ST_TRACK;
            convCount_ff <= '0;
            wakeCount_ff <= '0;
            holdCode_ff  <= '0;
            outReg_ff    <= '0;
        end else begin
            state_ff     <= nxt_state;
            convCount_ff <= nxt_convCount;
            wakeCount_ff <= nxt_wakeCount;
            holdCode_ff  <= nxt_holdCode;
            outReg_ff    <= nxt_outReg;
        end
    end

    // busy lags track and result by one cycle, so a host acting on its
    // falling edge already sees the new code; sleep starts with that edge
    conv_status_type status_ff, nxt_status;
    always_comb begin
        nxt_status.busy            = (nxt_state == ST_CONV)
                                     || convDone;
        nxt_status.holding         = (nxt_state == ST_CONV);
        nxt_status.sleeping        = ((nxt_state == ST_SLEEP)
                                     || (nxt_state == ST_WAKE))
                                     && !convDone;
        nxt_status.masterClockGate = (nxt_state == ST_CONV)
                                     || convDone;
    end

    logic selected;
    assign selected = ~(~csSync_ff[1] & ~rdSync_ff[1]);

    logic [RESULT_BITS-1:0] busData_ff, nxt_busData;
    logic                   busOe_n_ff, nxt_busOe_n;
    always_comb begin
        // drive only while both selects are low; tied low keeps it live
        nxt_busOe_n = selected;
        nxt_busData = nxt_outReg;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            status_ff  <= '0;
            busData_ff <= '0;
            busOe_n_ff <= 1'h1;
        end else begin
            status_ff  <= nxt_status;
            busData_ff <= nxt_busData;
            busOe_n_ff <= nxt_busOe_n;
        end
    end

    assign resultBus       = busData_ff;
    assign resultBusOe_n   = {RESULT_BITS{busOe_n_ff}};
    assign busy            = status_ff.busy;
    assign trackHold       = status_ff.holding;
    assign sleeping        = status_ff.sleeping;
    assign masterClockGate = status_ff.masterClockGate;

    // helper: busy must be high two cycles after start falls in track
    property p_busy_rise;
        @(posedge clock) disable iff (reset)
        (state_ff == ST_TRACK && startFall) |=> ##1 busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy late");

    property p_result_before_busy_fall;
        @(posedge clock) disable iff (reset)
        $fell(busy) |-> $past(resultBus) == outReg_ff;
    endproperty
    a_result_before_busy_fall: assert property (p_result_before_busy_fall)
        else $error("result not loaded at busy fall");

    property p_bus_enable;
        @(posedge clock) disable iff (reset)
        (!csSync_ff[1] && !rdSync_ff[1]) |=> !resultBusOe_n[0];
    endproperty
    a_bus_enable: assert property (p_bus_enable) else $error("bus not on");

    property p_bus_off;
        @(posedge clock) disable iff (reset)
        (csSync_ff[1] || rdSync_ff[1]) |=> resultBusOe_n[0];
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus not off");

    property p_conv_len;
        @(posedge clock) disable iff (reset)
        $fell(busy) |-> $past(convCount_ff, 2) == CONV_LAST;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("bad length");

    property p_sleep_entry;
        @(posedge clock) disable iff (reset)
        (convDone && startLow) |=> ##1 (sleeping && $fell(busy));
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep");

    property p_wake;
        @(posedge clock) disable iff (reset)
        (state_ff == ST_SLEEP && startRise) |=> ##[1:220] !sleeping;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_clock_gate;
        @(posedge clock) disable iff (reset)
        masterClockGate == busy;
    endproperty
    a_clock_gate: assert property (p_clock_gate) else $error("gate");

    property p_track_when_idle;
        @(posedge clock) disable iff (reset)
        !busy |-> !trackHold;
    endproperty
    a_track_when_idle: assert property (p_track_when_idle)
        else $error("hold while idle");

    property p_track_first;
        @(posedge clock) disable iff (reset)
        $fell(busy) |-> !$past(trackHold);
    endproperty
    a_track_first: assert property (p_track_first)
        else $error("still holding when busy fell");

    c_convert: cover property (@(posedge clock) disable iff (reset)
        $fell(busy) && !sleeping);
    c_sleep: cover property (@(posedge clock) disable iff (reset)
        $rose(sleeping));
    c_wake: cover property (@(posedge clock) disable iff (reset)
        $fell(sleeping));
    c_read: cover property (@(posedge clock) disable iff (reset)
        $fell(resultBusOe_n[0]));
endmodule
`default_nettype wire

// ==== design/sar_adc_pkg.sv ====
package sar_adc_pkg;
    // clock rate and derived counts
    localparam int  CLOCK_PERIOD_PS     = 5000;
    localparam int  START_PULSE_MIN_PS  = 15000;
    localparam int  START_PULSE_CYCLES  =
        (START_PULSE_MIN_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int  WAKEUP_TIME_NS      = 1000;
    localparam int  WAKEUP_CYCLES       = (WAKEUP_TIME_NS * 1000) / CLOCK_PERIOD_PS;
    localparam int  CONV_CYCLES_12BIT   = 14;
    localparam int  CONV_CYCLES_10BIT   = 12;
    localparam int  RESULT_BITS_12      = 12;
    localparam int  RESULT_BITS_10      = 10;
    localparam int  WAKE_WIDTH          = 8;
    localparam int  CONV_WIDTH          = 4;

    typedef enum logic [1:0] {
        ST_TRACK  = 2'b00,
        ST_CONV   = 2'b01,
        ST_SLEEP  = 2'b10,
        ST_WAKE   = 2'b11
    } conv_state_type;

    typedef struct packed {
        logic busy;
        logic holding;
        logic sleeping;
        logic masterClockGate;
    } conv_status_type;
endpackage

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic clock,
    input  wire logic trigger,
    input  wire logic keepLow,
    input  wire logic busy,
    output logic      conversionStart_n,
    output logic      masterClock
);
    int lowCount = 0;
    int runCount = -1;
    initial conversionStart_n = 1'b1;
    initial masterClock = 1'b0;
    always @(posedge clock) begin
        lowCount <= lowCount + 1;
        if (trigger) begin
            conversionStart_n <= 1'b0;
            lowCount <= 0;
            runCount <= 0;
        end else if (lowCount >= 2 && !keepLow) begin
            conversionStart_n <= 1'b1; // 15 ns pulse, rise wakes
        end
        if (runCount >= 0 && !trigger) runCount <= runCount + 1;
        // idles low outside conversions; 25 MHz, first edge 25 ns late
        masterClock <= runCount >= 4 && (runCount - 4) % 8 < 4;
        if (runCount > 8 && !busy) runCount <= -1;
    end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sar_adc_pkg::*;
    localparam int BITS  = RESULT_BITS_12;
    localparam int CONV  = CONV_CYCLES_12BIT;
    localparam int LIMIT = 20000;
    logic            clock        = 1'b0;
    logic            reset        = 1'b1;
    logic            trigger      = 1'b0;
    logic            keepLow      = 1'b0;
    logic            chipSelect_n = 1'b1;
    logic            read_n       = 1'b1;
    logic [BITS-1:0] sampleCode   = '0;
    logic [BITS-1:0] resultBus;
    logic [BITS-1:0] resultBusOe_n;
    logic            conversionStart_n;
    logic            masterClock;
    logic            busy, trackHold, sleeping, masterClockGate;
    logic [31:0]     seed         = 32'hce5550a9;
    int              err_count    = 0;
    int              check_count  = 0;
    int              cycles       = 0;

    host_model host_model_inst (.clock(clock), .trigger(trigger),
        .keepLow(keepLow), .busy(busy),
        .conversionStart_n(conversionStart_n), .masterClock(masterClock));
    sar_adc_parallel_readout #(.RESULT_BITS(BITS), .CONV_CYCLES(CONV))
        sar_adc_parallel_readout_inst (.clock(clock), .reset(reset),
        .conversionStart_n(conversionStart_n), .masterClock(masterClock),
        .chipSelect_n(chipSelect_n), .read_n(read_n),
        .sampleCode(sampleCode), .resultBus(resultBus),
        .resultBusOe_n(resultBusOe_n), .busy(busy), .trackHold(trackHold),
        .sleeping(sleeping), .masterClockGate(masterClockGate));

    always #2.5 clock = ~clock;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // enable is active low, all bits alike
    function automatic logic [BITS-1:0] oeFor(input logic sel);
        return sel ? '0 : '1;
    endfunction

    // edges seen late, so allow half a master period of slack below and one and a half above
    function automatic logic spanOk(input int k);
        return k >= (CONV - 1) * 8 - 4 && k <= (CONV - 1) * 8 + 12;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            summarize();
        end
    end

    task automatic convert(input logic [BITS-1:0] code, input logic tie,
                           input logic hold);
        int k;
        logic prevHold;
        logic [BITS-1:0] lastBus;
        @(negedge clock);
        sampleCode = code;
        keepLow = hold;
        chipSelect_n = !tie;
        read_n = !tie;
        trigger = 1'b1;
        @(negedge clock);
        trigger = 1'b0;
        k = 0;
        while (busy !== 1'b1 && k < 10) begin
            @(negedge clock);
            k++;
        end
        check(k < 8 && busy === 1'b1, 1'b1);
        seed = xorshift(seed);
        sampleCode = seed[BITS-1:0]; // must not reach this result
        k = 0;
        prevHold = 1'b1;
        lastBus = '0;
        // hold is checked one cycle late: the last busy cycle must track
        while (busy === 1'b1 && k < 400) begin
            check(prevHold, 1'b1);
            check(masterClockGate, 1'b1);
            if (tie) check(resultBusOe_n, oeFor(1'b1));
            prevHold = trackHold;
            lastBus = resultBus;
            @(negedge clock);
            k++;
        end
        check(spanOk(k), 1'b1);
        check(prevHold, 1'b0);
        check({trackHold, masterClockGate}, 2'b00);
        check(sleeping, hold);
        if (tie) check(lastBus, code);
        if (tie) check(resultBus, code);
    endtask

    task automatic wake;
        repeat (50) @(negedge clock);
        check(sleeping, 1'b1);
        keepLow = 1'b0;
        repeat (WAKEUP_CYCLES - 10) @(negedge clock);
        check(sleeping, 1'b1);
        repeat (20) @(negedge clock);
        check(sleeping, 1'b0);
    endtask

    task automatic fetch(input logic [BITS-1:0] code, input logic csFirst);
        if (csFirst) chipSelect_n = 1'b0;
        else read_n = 1'b0;
        repeat (5) @(negedge clock);
        check(resultBusOe_n, oeFor(1'b0));
        if (csFirst) read_n = 1'b0;
        else chipSelect_n = 1'b0;
        repeat (4) @(negedge clock);
        check(resultBusOe_n, oeFor(1'b1));
        check(resultBus, code);
        if (csFirst) chipSelect_n = 1'b1;
        else read_n = 1'b1;
        repeat (4) @(negedge clock);
        check(resultBusOe_n, oeFor(1'b0));
        chipSelect_n = 1'b1;
        read_n = 1'b1;
    endtask

    initial begin
        int i;
        logic t;
        logic [BITS-1:0] c;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        repeat (3) @(negedge clock);
        check({busy, sleeping, trackHold, masterClockGate}, 4'h0);
        check(resultBusOe_n, oeFor(1'b0));
        convert('0, 1'b0, 1'b0); // result thrown away
        for (i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            c = (i == 0) ? '1 : (i == 1) ? '0 : seed[BITS-1:0];
            t = seed[20] && i > 1;
            convert(c, t, i == 2);
            if (i == 2) wake();
            if (t) begin
                chipSelect_n = 1'b1;
                read_n = 1'b1;
            end else begin
                fetch(c, seed[21]);
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
